// File: rtl/oseq_lin11_ms.sv
// linear11 time word to whole milliseconds, saturating
`timescale 1ns/10ps
module oseq_lin11_ms #(
  parameter int OW = 17
) (
  input  wire logic [15:0]   i_word,
  output logic      [OW-1:0] o_ms
);
  logic signed [4:0] exp_s;
  logic        [9:0] mant;
  logic        [47:0] wide;
  localparam logic [47:0] SAT = 48'((64'h1 << OW) - 1);

  always_comb begin
    exp_s = i_word[oseq_pkg::L11_EXP_MSB:oseq_pkg::L11_EXP_LSB];
    mant  = i_word[oseq_pkg::L11_MANT_MSB-1:0];
    if (exp_s < 0) begin
      wide = {38'h0, mant} >> (-exp_s);
    end else begin
      wide = {38'h0, mant} << exp_s;
    end
    // negative times read as zero
    if (i_word[oseq_pkg::L11_MANT_MSB]) begin
      o_ms = '0;
    end else if (wide > SAT) begin
      o_ms = SAT[OW-1:0];
    end else begin
      o_ms = wide[OW-1:0];
    end
  end
endmodule : oseq_lin11_ms

// File: rtl/oseq_ms_tick.sv
// one-cycle pulse every millisecond
`timescale 1ns/10ps
module oseq_ms_tick #(
  parameter int CYC_PER_MS = oseq_pkg::CYC_PER_MS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  oseq_tick_if.src  tick_if
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } oseq_tick_s;

  oseq_tick_s s_r;
  oseq_tick_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= 32'(CYC_PER_MS - 1)) begin
      s_nxt.cnt  = 32'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_if.tick = s_r.tick;
endmodule : oseq_ms_tick

// File: rtl/oseq_pkg.sv
// constants and types shared by the output sequencing block
package oseq_pkg;
  // command codes of the sequencing and status registers
  localparam logic [7:0] CMD_PG_ASSERT   = 8'h5e;
  localparam logic [7:0] CMD_PG_RELEASE  = 8'h5f;
  localparam logic [7:0] CMD_TON_WAIT    = 8'h60;
  localparam logic [7:0] CMD_TON_RAMP    = 8'h61;
  localparam logic [7:0] CMD_TON_TIMEOUT = 8'h62;
  localparam logic [7:0] CMD_TOFF_WAIT   = 8'h64;
  localparam logic [7:0] CMD_TOFF_RAMP   = 8'h65;
  localparam logic [7:0] CMD_TOFF_WARN   = 8'h66;
  localparam logic [7:0] CMD_SUMMARY     = 8'h78;
  localparam logic [7:0] CMD_EXT_STATUS  = 8'h79;
  localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;

  // index of each time register in the time array
  localparam int T_TON_WAIT    = 0;
  localparam int T_TON_RAMP    = 1;
  localparam int T_TON_TIMEOUT = 2;
  localparam int T_TOFF_WAIT   = 3;
  localparam int T_TOFF_RAMP   = 4;
  localparam int T_TOFF_WARN   = 5;
  localparam int T_NUM         = 6;

  localparam logic [15:0] RST_THRESH = 16'h0000;
  localparam logic [15:0] RST_TIME   = 16'h0000;

  // times in milliseconds
  localparam logic [16:0] MIN_TON_WAIT_MS    = 17'h00001;
  localparam logic [16:0] RESTART_EXTRA_MS   = 17'h00027;
  localparam logic [16:0] MIN_RAMP_MS        = 17'h0000a;
  localparam logic [16:0] SHARE_RAMP_MS      = 17'h000c8;
  localparam logic [16:0] TON_MARGIN_MS      = 17'h0000a;
  localparam logic [16:0] TON_SHARE_MARGIN_MS = 17'h000c8;
  localparam logic [16:0] MIN_FALL_MS        = 17'h0000a;
  localparam logic [16:0] TOFF_MARGIN_MS     = 17'h00005;

  // clock timing: 1 ms tick derived from the clock period
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_IN_NS      = 1000000;
  localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;

  // summary status bit positions
  localparam int SB_VOUT_OV  = 5;
  localparam int SB_IOUT_OC  = 4;
  localparam int SB_VIN_UV   = 3;
  localparam int SB_TEMP     = 2;
  localparam int SB_CML      = 1;
  // extended status high bits
  localparam int SW_VOUT     = 15;
  localparam int SW_IOUT     = 14;
  localparam int SW_VIN      = 13;
  // output voltage status bit positions
  localparam int SV_OV_FAULT = 7;
  localparam int SV_OV_WARN  = 6;
  localparam int SV_UV_WARN  = 5;
  localparam int SV_UV_FAULT = 4;
  localparam int SV_MAX_WARN = 3;
  localparam int SV_TON_MAX  = 2;
  localparam int SV_TOFF_MAX = 1;

  // linear11 fields
  localparam int L11_EXP_MSB  = 15;
  localparam int L11_EXP_LSB  = 11;
  localparam int L11_MANT_MSB = 10;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ON_WAIT,
    ST_RISE,
    ST_ON,
    ST_OFF_WAIT,
    ST_FALL,
    ST_ABNORMAL
  } oseq_state_e;
endpackage : oseq_pkg

// File: rtl/oseq_sequencer.sv
// output turn-on/turn-off sequencing, power-good and status registers
`timescale 1ns/10ps
module oseq_sequencer #(
  parameter int CYC_PER_MS = oseq_pkg::CYC_PER_MS
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic        i_wr_stb,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_rd_stb,
  input  wire logic        i_clear_faults,
  input  wire logic        i_remote_enable,
  input  wire logic        i_bus_ctrl_enable,
  input  wire logic        i_operation_on,
  input  wire logic        i_droop_load_sharing,
  input  wire logic        i_bus_current_sharing,
  input  wire logic [15:0] i_vout,
  input  wire logic        i_vout_ov_fault,
  input  wire logic        i_vout_ov_warn,
  input  wire logic        i_vout_uv_warn,
  input  wire logic        i_vout_uv_fault,
  input  wire logic        i_vout_above_max,
  input  wire logic        i_iout_oc_fault,
  input  wire logic        i_iout_event,
  input  wire logic        i_vin_uv_fault,
  input  wire logic        i_vin_event,
  input  wire logic        i_temp_event,
  input  wire logic        i_cml_fault,
  output logic      [15:0] o_rd_data,
  output logic             o_rd_valid,
  output logic             o_power_good_output_pin_n,
  output logic             o_fault_alert_pin_n,
  output logic             o_output_on,
  output logic             o_ramp_up,
  output logic             o_ramp_down,
  output logic      [16:0] o_ramp_ms
);
  typedef struct packed {
    oseq_pkg::oseq_state_e   st;
    logic [15:0]             pg_on;
    logic [15:0]             pg_off;
    logic [oseq_pkg::T_NUM-1:0][15:0] treg;
    logic [16:0]             ms;
    logic                    first_start;
    logic                    pg_seen;
    logic                    ton_flt;
    logic                    toff_wrn;
    logic                    pg_n;
    logic                    alert_n;
    logic [15:0]             rd_data;
    logic                    rd_valid;
    logic                    out_on;
    logic                    ramp_up;
    logic                    ramp_dn;
    logic [16:0]             ramp_ms;
  } oseq_seq_s;

  oseq_seq_s s_r;
  oseq_seq_s s_nxt;

  logic        rst_meta_r;
  logic        rst_n_r;
  logic [oseq_pkg::T_NUM-1:0][16:0] t_ms;
  logic        share;
  logic        en_req;
  logic [16:0] ton_wait_eff;
  logic [16:0] rise_eff;
  logic [16:0] ton_max_min;
  logic [16:0] ton_max_eff;
  logic [16:0] fall_eff;
  logic [16:0] warn_min;
  logic [16:0] warn_eff;
  logic [7:0]  summary;
  logic [7:0]  vout_stat;
  logic        vout_hi;
  logic        vout_lo;

  oseq_tick_if tick_if ();

  // reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  oseq_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_r),
    .tick_if (tick_if.src)
  );

  // decode each linear11 time register to milliseconds
  for (genvar g = 0; g < oseq_pkg::T_NUM; g++) begin : g_conv
    oseq_lin11_ms #(
      .OW (17)
    ) u_conv (
      .i_word (s_r.treg[g]),
      .o_ms   (t_ms[g])
    );
  end

  // effective times after minimum enforcement
  always_comb begin
    share  = i_droop_load_sharing | i_bus_current_sharing;
    // all three enable paths must agree; any one drop disables
    en_req = i_remote_enable & i_bus_ctrl_enable & i_operation_on;
    if (t_ms[oseq_pkg::T_TON_WAIT] < oseq_pkg::MIN_TON_WAIT_MS) begin
      ton_wait_eff = oseq_pkg::MIN_TON_WAIT_MS;
    end else begin
      ton_wait_eff = t_ms[oseq_pkg::T_TON_WAIT];
    end
    if (s_r.first_start) begin
      ton_wait_eff = ton_wait_eff + oseq_pkg::RESTART_EXTRA_MS;
    end
    if (share) begin
      rise_eff    = oseq_pkg::SHARE_RAMP_MS;
      ton_max_min = rise_eff + oseq_pkg::TON_SHARE_MARGIN_MS;
    end else begin
      if (t_ms[oseq_pkg::T_TON_RAMP] < oseq_pkg::MIN_RAMP_MS) begin
        rise_eff = oseq_pkg::MIN_RAMP_MS;
      end else begin
        rise_eff = t_ms[oseq_pkg::T_TON_RAMP];
      end
      ton_max_min = rise_eff + oseq_pkg::TON_MARGIN_MS;
    end
    if (t_ms[oseq_pkg::T_TON_TIMEOUT] < ton_max_min) begin
      ton_max_eff = ton_max_min;
    end else begin
      ton_max_eff = t_ms[oseq_pkg::T_TON_TIMEOUT];
    end
    if (t_ms[oseq_pkg::T_TOFF_RAMP] < oseq_pkg::MIN_FALL_MS) begin
      fall_eff = oseq_pkg::MIN_FALL_MS;
    end else begin
      fall_eff = t_ms[oseq_pkg::T_TOFF_RAMP];
    end
    warn_min = fall_eff + oseq_pkg::TOFF_MARGIN_MS;
    if (t_ms[oseq_pkg::T_TOFF_WARN] < warn_min) begin
      warn_eff = warn_min;
    end else begin
      warn_eff = t_ms[oseq_pkg::T_TOFF_WARN];
    end
    vout_hi = i_vout > s_r.pg_on;
    vout_lo = i_vout < s_r.pg_off;
  end

  // status bytes from live inputs and latched timing faults
  always_comb begin
    summary                       = 8'h00;
    summary[oseq_pkg::SB_VOUT_OV] = i_vout_ov_fault;
    summary[oseq_pkg::SB_IOUT_OC] = i_iout_oc_fault;
    summary[oseq_pkg::SB_VIN_UV]  = i_vin_uv_fault;
    summary[oseq_pkg::SB_TEMP]    = i_temp_event;
    summary[oseq_pkg::SB_CML]     = i_cml_fault;
    vout_stat                          = 8'h00;
    vout_stat[oseq_pkg::SV_OV_FAULT]   = i_vout_ov_fault;
    vout_stat[oseq_pkg::SV_OV_WARN]    = i_vout_ov_warn;
    vout_stat[oseq_pkg::SV_UV_WARN]    = i_vout_uv_warn;
    vout_stat[oseq_pkg::SV_UV_FAULT]   = i_vout_uv_fault;
    vout_stat[oseq_pkg::SV_MAX_WARN]   = i_vout_above_max;
    vout_stat[oseq_pkg::SV_TON_MAX]    = s_r.ton_flt;
    vout_stat[oseq_pkg::SV_TOFF_MAX]   = s_r.toff_wrn;
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.rd_valid = 1'b0;

    // register writes; status registers ignore writes
    if (i_wr_stb) begin
      if (i_cmd_code == oseq_pkg::CMD_PG_ASSERT) begin
        s_nxt.pg_on = i_wr_data;
      end else if (i_cmd_code == oseq_pkg::CMD_PG_RELEASE) begin
        s_nxt.pg_off = i_wr_data;
      end else if (i_cmd_code == oseq_pkg::CMD_TON_WAIT) begin
        s_nxt.treg[oseq_pkg::T_TON_WAIT] = i_wr_data;
      end else if (i_cmd_code == oseq_pkg::CMD_TON_RAMP) begin
        s_nxt.treg[oseq_pkg::T_TON_RAMP] = i_wr_data;
      end else if (i_cmd_code == oseq_pkg::CMD_TON_TIMEOUT) begin
        s_nxt.treg[oseq_pkg::T_TON_TIMEOUT] = i_wr_data;
      end else if (i_cmd_code == oseq_pkg::CMD_TOFF_WAIT) begin
        s_nxt.treg[oseq_pkg::T_TOFF_WAIT] = i_wr_data;
      end else if (i_cmd_code == oseq_pkg::CMD_TOFF_RAMP) begin
        s_nxt.treg[oseq_pkg::T_TOFF_RAMP] = i_wr_data;
      end else if (i_cmd_code == oseq_pkg::CMD_TOFF_WARN) begin
        s_nxt.treg[oseq_pkg::T_TOFF_WARN] = i_wr_data;
      end
    end

    // register reads; unknown codes answer zero
    if (i_rd_stb) begin
      s_nxt.rd_valid = 1'b1;
      if (i_cmd_code == oseq_pkg::CMD_PG_ASSERT) begin
        s_nxt.rd_data = s_r.pg_on;
      end else if (i_cmd_code == oseq_pkg::CMD_PG_RELEASE) begin
        s_nxt.rd_data = s_r.pg_off;
      end else if (i_cmd_code == oseq_pkg::CMD_TON_WAIT) begin
        s_nxt.rd_data = s_r.treg[oseq_pkg::T_TON_WAIT];
      end else if (i_cmd_code == oseq_pkg::CMD_TON_RAMP) begin
        s_nxt.rd_data = s_r.treg[oseq_pkg::T_TON_RAMP];
      end else if (i_cmd_code == oseq_pkg::CMD_TON_TIMEOUT) begin
        s_nxt.rd_data = s_r.treg[oseq_pkg::T_TON_TIMEOUT];
      end else if (i_cmd_code == oseq_pkg::CMD_TOFF_WAIT) begin
        s_nxt.rd_data = s_r.treg[oseq_pkg::T_TOFF_WAIT];
      end else if (i_cmd_code == oseq_pkg::CMD_TOFF_RAMP) begin
        s_nxt.rd_data = s_r.treg[oseq_pkg::T_TOFF_RAMP];
      end else if (i_cmd_code == oseq_pkg::CMD_TOFF_WARN) begin
        s_nxt.rd_data = s_r.treg[oseq_pkg::T_TOFF_WARN];
      end else if (i_cmd_code == oseq_pkg::CMD_SUMMARY) begin
        s_nxt.rd_data = {8'h00, summary};
      end else if (i_cmd_code == oseq_pkg::CMD_EXT_STATUS) begin
        s_nxt.rd_data = {|vout_stat, i_iout_event, i_vin_event,
                         5'h00, summary};
      end else if (i_cmd_code == oseq_pkg::CMD_VOUT_STATUS) begin
        s_nxt.rd_data = {8'h00, vout_stat};
      end else begin
        s_nxt.rd_data = 16'h0000;
      end
    end

    // clear first so a same-cycle set wins
    if (i_clear_faults) begin
      s_nxt.ton_flt  = 1'b0;
      s_nxt.toff_wrn = 1'b0;
    end

    if (tick_if.tick && (s_r.ms != '1)) begin
      s_nxt.ms = s_r.ms + 17'h1;
    end

    case (s_r.st)
      oseq_pkg::ST_OFF: begin
        if (en_req) begin
          s_nxt.st = oseq_pkg::ST_ON_WAIT;
          s_nxt.ms = '0;
        end
      end
      oseq_pkg::ST_ON_WAIT: begin
        if (!en_req) begin
          s_nxt.st = oseq_pkg::ST_OFF;
        end else if (s_r.ms >= ton_wait_eff) begin
          s_nxt.st          = oseq_pkg::ST_RISE;
          s_nxt.ms          = '0;
          s_nxt.first_start = 1'b0;
          s_nxt.pg_seen     = 1'b0;
          s_nxt.out_on      = 1'b1;
          s_nxt.ramp_up     = 1'b1;
          s_nxt.ramp_ms     = rise_eff;
        end
      end
      oseq_pkg::ST_RISE, oseq_pkg::ST_ON: begin
        if (vout_hi) begin
          s_nxt.pg_seen = 1'b1;
        end
        // timeout counted from the start of rise
        if (!s_r.pg_seen && !vout_hi &&
            (s_r.treg[oseq_pkg::T_TON_TIMEOUT] != 16'h0000) &&
            (s_r.ms >= ton_max_eff)) begin
          s_nxt.ton_flt = 1'b1;
        end
        if (!en_req) begin
          s_nxt.st      = oseq_pkg::ST_OFF_WAIT;
          s_nxt.ms      = '0;
          s_nxt.ramp_up = 1'b0;
        end else if ((s_r.st == oseq_pkg::ST_RISE) &&
                     (s_r.ms >= rise_eff)) begin
          s_nxt.st      = oseq_pkg::ST_ON;
          s_nxt.ramp_up = 1'b0;
        end
      end
      oseq_pkg::ST_OFF_WAIT: begin
        if (s_r.ms >= t_ms[oseq_pkg::T_TOFF_WAIT]) begin
          s_nxt.st      = oseq_pkg::ST_FALL;
          s_nxt.ms      = '0;
          s_nxt.out_on  = 1'b0;
          s_nxt.ramp_dn = 1'b1;
          s_nxt.ramp_ms = fall_eff;
        end
      end
      oseq_pkg::ST_FALL: begin
        if (vout_lo && (s_r.ms >= fall_eff)) begin
          s_nxt.st      = oseq_pkg::ST_OFF;
          s_nxt.ramp_dn = 1'b0;
        end else if (!vout_lo && (s_r.ms >= warn_eff)) begin
          s_nxt.toff_wrn = 1'b1;
          s_nxt.st       = oseq_pkg::ST_ABNORMAL;
          s_nxt.ramp_dn  = 1'b0;
        end
      end
      oseq_pkg::ST_ABNORMAL: begin
        s_nxt.st = oseq_pkg::ST_ABNORMAL;
      end
      default: begin
        s_nxt.st = oseq_pkg::ST_OFF;
      end
    endcase

    // power-good pin, active low
    if ((s_nxt.st == oseq_pkg::ST_ON_WAIT) ||
        (s_nxt.st == oseq_pkg::ST_RISE)) begin
      s_nxt.pg_n = 1'b1;
    end else if (vout_lo) begin
      s_nxt.pg_n = 1'b1;
    end else if (vout_hi && (s_nxt.st == oseq_pkg::ST_ON)) begin
      s_nxt.pg_n = 1'b0;
    end

    s_nxt.alert_n = !(s_nxt.ton_flt || s_nxt.toff_wrn);
  end

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r             <= '0;
      s_r.st          <= oseq_pkg::ST_OFF;
      s_r.pg_on       <= oseq_pkg::RST_THRESH;
      s_r.pg_off      <= oseq_pkg::RST_THRESH;
      s_r.treg        <= {oseq_pkg::T_NUM{oseq_pkg::RST_TIME}};
      s_r.first_start <= 1'b1;
      s_r.pg_n        <= 1'b1;
      s_r.alert_n     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rd_data                 = s_r.rd_data;
  assign o_rd_valid                = s_r.rd_valid;
  assign o_power_good_output_pin_n = s_r.pg_n;
  assign o_fault_alert_pin_n       = s_r.alert_n;
  assign o_output_on               = s_r.out_on;
  assign o_ramp_up                 = s_r.ramp_up;
  assign o_ramp_down               = s_r.ramp_dn;
  assign o_ramp_ms                 = s_r.ramp_ms;
endmodule : oseq_sequencer

// File: rtl/oseq_tick_if.sv
// millisecond tick carried from the tick generator to the sequencer
`timescale 1ns/10ps
interface oseq_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface : oseq_tick_if

// File: testbench/oseq_host.sv
// management host driving command writes and reads
`timescale 1ns/10ps
module oseq_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  output logic      [7:0]  o_cmd_code,
  output logic             o_wr_stb,
  output logic      [15:0] o_wr_data,
  output logic             o_rd_stb
);
  initial begin
    o_cmd_code = 8'h00;
    o_wr_stb = 1'b0;
    o_wr_data = 16'h0000;
    o_rd_stb = 1'b0;
  end
  // idle bus shows inverted last value
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge i_clk);
    o_cmd_code = c;
    o_wr_data = d;
    o_wr_stb = 1'b1;
    @(negedge i_clk);
    o_wr_stb = 1'b0;
    o_cmd_code = ~c;
    o_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int n;
    @(negedge i_clk);
    o_cmd_code = c;
    o_rd_stb = 1'b1;
    @(negedge i_clk);
    o_rd_stb = 1'b0;
    o_cmd_code = ~c;
    n = 0;
    while (i_rd_valid !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    d = (i_rd_valid === 1'b1) ? i_rd_data : 16'hxxxx;
  endtask : rd
endmodule : oseq_host

// File: testbench/oseq_monitor.sv
// port assertions for the output sequencer
`timescale 1ns/10ps
module oseq_monitor #(
  parameter int CYC_PER_MS = 20
) (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [7:0]  i_cmd_code,
  input wire logic        i_rd_stb,
  input wire logic        i_clear_faults,
  input wire logic        i_droop_load_sharing,
  input wire logic        i_bus_current_sharing,
  input wire logic        i_vout_ov_fault,
  input wire logic        i_iout_event,
  input wire logic        i_vin_event,
  input wire logic        i_vout_above_max,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic        o_power_good_output_pin_n,
  input wire logic        o_fault_alert_pin_n,
  input wire logic        o_output_on,
  input wire logic        o_ramp_up,
  input wire logic        o_ramp_down,
  input wire logic [16:0] o_ramp_ms
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  logic share;
  assign share = i_droop_load_sharing | i_bus_current_sharing;

  read_answer_a: assert property (i_rd_stb |=> o_rd_valid)
    else $error("read not answered");
  summary_ov_a: assert property (i_rd_stb && i_cmd_code == 8'h78
    |=> o_rd_data[5] == $past(i_vout_ov_fault))
    else $error("summary bit 5 wrong");
  ext_events_a: assert property (i_rd_stb && i_cmd_code == 8'h79
    |=> o_rd_data[14:13] == $past({i_iout_event, i_vin_event}))
    else $error("extended event bits wrong");
  vout_max_a: assert property (i_rd_stb && i_cmd_code == 8'h7a
    |=> o_rd_data[3] == $past(i_vout_above_max))
    else $error("output status bit 3 wrong");
  pg_startup_a: assert property (o_ramp_up
    |-> o_power_good_output_pin_n)
    else $error("power good active in rise");
  pg_on_a: assert property ($fell(o_power_good_output_pin_n)
    |-> o_output_on && !o_ramp_up)
    else $error("power good outside on state");
  rise_start_a: assert property ($rose(o_ramp_up)
    |-> o_output_on && !o_ramp_down && o_ramp_ms >= 17'h0000a)
    else $error("bad rise start");
  share_rise_a: assert property ($rose(o_ramp_up) && share
    |-> o_ramp_ms == 17'h000c8)
    else $error("sharing rise time wrong");
  fall_start_a: assert property ($rose(o_ramp_down)
    |-> !o_output_on && o_ramp_ms >= 17'h0000a)
    else $error("bad fall start");
  alert_latch_a: assert property (!o_fault_alert_pin_n
    && !i_clear_faults && !$past(i_clear_faults) |=> !o_fault_alert_pin_n)
    else $error("alert released without clear");
endmodule : oseq_monitor

bind oseq_sequencer oseq_monitor #(.CYC_PER_MS(CYC_PER_MS)) i_mon (
  .i_clk, .i_rstn, .i_cmd_code, .i_rd_stb, .i_clear_faults,
  .i_droop_load_sharing, .i_bus_current_sharing, .i_vout_ov_fault,
  .i_iout_event, .i_vin_event, .i_vout_above_max, .o_rd_data,
  .o_rd_valid, .o_power_good_output_pin_n, .o_fault_alert_pin_n,
  .o_output_on, .o_ramp_up, .o_ramp_down, .o_ramp_ms
);

// File: testbench/test_output_sequencing_status.sv
// self-checking bench for the output sequencing block
`timescale 1ns/10ps
module test_output_sequencing_status;
  localparam int C = 20;
  logic        clk = 1'b0, rstn, clr, en_r, en_b, en_o, droop_load_sharing, bcs;
  logic [7:0]  cmd;
  logic        wr, rd, rdv, pg_n, al_n, on, up, dn, ton_f, toff_f;
  logic [15:0] wd, rdd, vout, regs[logic [7:0]];
  logic [10:0] st;
  logic [16:0] rms;
  int          n_errors = 0, n_tests = 0, seed;
  logic [7:0]  rw[8] = '{8'h5e, 8'h5f, 8'h60, 8'h61, 8'h62, 8'h64,
                         8'h65, 8'h66};
  logic [15:0] cfg[8] = '{16'h4000, 16'h2000, 16'h0000, 16'h0806,
                          16'h0000, 16'h0003, 16'h0000, 16'h0000};
  logic [7:0]  sc[3] = '{8'h78, 8'h79, 8'h7a};

  always #2.5 clk = ~clk;

  oseq_host i_host (.i_clk(clk), .i_rd_data(rdd), .i_rd_valid(rdv),
    .o_cmd_code(cmd), .o_wr_stb(wr), .o_wr_data(wd), .o_rd_stb(rd));

  oseq_sequencer #(.CYC_PER_MS(C)) i_dut (.i_clk(clk), .i_rstn(rstn),
    .i_cmd_code(cmd), .i_wr_stb(wr), .i_wr_data(wd), .i_rd_stb(rd),
    .i_clear_faults(clr), .i_remote_enable(en_r),
    .i_bus_ctrl_enable(en_b), .i_operation_on(en_o),
    .i_droop_load_sharing(droop_load_sharing), .i_bus_current_sharing(bcs),
    .i_vout(vout), .i_vout_ov_fault(st[10]), .i_vout_ov_warn(st[9]),
    .i_vout_uv_warn(st[8]), .i_vout_uv_fault(st[7]),
    .i_vout_above_max(st[6]), .i_iout_oc_fault(st[5]),
    .i_iout_event(st[4]), .i_vin_uv_fault(st[3]), .i_vin_event(st[2]),
    .i_temp_event(st[1]), .i_cml_fault(st[0]), .o_rd_data(rdd),
    .o_rd_valid(rdv), .o_power_good_output_pin_n(pg_n),
    .o_fault_alert_pin_n(al_n), .o_output_on(on), .o_ramp_up(up),
    .o_ramp_down(dn), .o_ramp_ms(rms));

  function automatic logic [15:0] exp_st(input logic [7:0] c);
    logic [7:0] sb;
    logic [7:0] vs;
    sb = {2'b00, st[10], st[5], st[3], st[1], st[0], 1'b0};
    vs = {st[10:6], ton_f, toff_f, 1'b0};
    case (c)
      8'h78: exp_st = {8'h00, sb};
      8'h79: exp_st = {|vs, st[4], st[2], 5'h00, sb};
      default: exp_st = {8'h00, vs};
    endcase
  endfunction : exp_st

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    i_host.rd(c, d);
    chk({1'b0, d}, {1'b0, e});
  endtask : rdchk

  // counts falling edges until a pin reaches a level
  task automatic dur(input int w, input logic lv, input int lo, input int hi);
    int n;
    n = 0;
    while ((w == 0 ? up : w == 1 ? dn : al_n) !== lv && n <= hi) begin
      @(negedge clk);
      n++;
    end
    n_tests++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("[ERR] %0t took %0d cycles, not %0d..%0d", $time, n, lo, hi);
    end
  endtask : dur

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h9ab2;
    {rstn, clr, en_r, en_b, en_o, droop_load_sharing, bcs, ton_f, toff_f} = '0;
    vout = 16'h0000;
    st = 11'h000;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rw[i]) rdchk(rw[i], 16'h0000);
    rdchk(8'h33, 16'h0000);
    foreach (rw[i]) begin
      regs[rw[i]] = 16'($random(seed));
      i_host.wr(rw[i], regs[rw[i]]);
    end
    foreach (rw[i]) rdchk(rw[i], regs[rw[i]]);
    i_host.wr(8'h79, 16'hffff);
    rdchk(8'h79, exp_st(8'h79));
    repeat (8) begin
      @(negedge clk);
      st = 11'($random(seed));
      foreach (sc[k]) rdchk(sc[k], exp_st(sc[k]));
    end
    $display("test registers done");
    foreach (rw[i]) i_host.wr(rw[i], cfg[i]);
    {en_r, en_b, en_o} = 3'b111;
    dur(0, 1'b1, 39 * C, 40 * C + 4);
    chk(rms, 17'h0000c);
    chk({16'h0000, pg_n}, 17'h00001);
    dur(0, 1'b0, 11 * C, 12 * C + 4);
    repeat (12 * C) @(negedge clk);
    chk({15'h0000, al_n, pg_n}, 17'h00003);
    vout = 16'h5000;
    repeat (3) @(negedge clk);
    chk({16'h0000, pg_n}, 17'h00000);
    en_r = 1'b0;
    dur(1, 1'b1, 2 * C, 3 * C + 4);
    chk({on, rms[15:0]}, 17'h0000a);
    vout = 16'h1000;
    dur(1, 1'b0, 9 * C, 10 * C + 4);
    chk({15'h0000, al_n, pg_n}, 17'h00003);
    $display("test first start done");
    bcs = 1'b1;
    en_o = 1'b0;
    i_host.wr(8'h60, 16'h0002);
    i_host.wr(8'h62, 16'h0001);
    en_r = 1'b1;
    @(negedge clk);
    en_o = 1'b1;
    dur(0, 1'b1, C, 2 * C + 4);
    chk(rms, 17'h000c8);
    dur(2, 1'b0, 399 * C, 400 * C + 4);
    ton_f = 1'b1;
    rdchk(8'h7a, exp_st(8'h7a));
    rdchk(8'h79, exp_st(8'h79));
    vout = 16'h5000;
    repeat (3) @(negedge clk);
    chk({16'h0000, al_n}, 17'h00000);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    ton_f = 1'b0;
    repeat (3) @(negedge clk);
    chk({16'h0000, al_n}, 17'h00001);
    $display("test shared start done");
    en_b = 1'b0;
    dur(1, 1'b1, 2 * C, 3 * C + 4);
    dur(2, 1'b0, 14 * C, 15 * C + 4);
    toff_f = 1'b1;
    rdchk(8'h7a, exp_st(8'h7a));
    en_b = 1'b1;
    repeat (45 * C) @(negedge clk);
    chk({15'h0000, up, on}, 17'h00000);
    chk({16'h0000, al_n}, 17'h00000);
    $display("test stuck output done");
    bcs = 1'b0;
    droop_load_sharing = 1'b1;
    en_o = 1'b0;
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk({15'h0000, al_n, pg_n}, 17'h00003);
    rdchk(8'h66, 16'h0000);
    en_o = 1'b1;
    dur(0, 1'b1, 39 * C, 40 * C + 4);
    chk(rms, 17'h000c8);
    $display("test restart done");
    tally_and_finish();
  end
endmodule : test_output_sequencing_status
